// ### hdl/gated_counter_timer_pkg.sv
package gated_counter_timer_pkg;

    // =========================================================
    // Clock and timing
    // =========================================================
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned DISPLAY_PAUSE_MS = 300;   // Pause between continuous readings
    localparam int unsigned HOLD_PROC_MS     = 100;   // Result processing time in hold mode
    localparam int unsigned GATE_UNIT_US     = 100;   // One gate step
    localparam int unsigned PAUSE_CYC_DEF   = DISPLAY_PAUSE_MS * 1000 * CLK_MHZ;
    localparam int unsigned PROC_CYC_DEF    = HOLD_PROC_MS * 1000 * CLK_MHZ;
    localparam int unsigned GATE_UNIT_CYC_DEF = GATE_UNIT_US * CLK_MHZ;
    localparam int unsigned GATE_1S_UNITS   = 10000;  // Gate steps in one second
    localparam int unsigned DIGITS_1S       = 8;      // Digits at a one second gate

    // =========================================================
    // Register map (byte offsets)
    // =========================================================
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] GATE_OFS   = 8'h04;
    localparam logic [7:0] STAT_OFS   = 8'h08;
    localparam logic [7:0] RESULT_OFS = 8'h0C;
    localparam logic [7:0] IRQ_STS_OFS = 8'h10;
    localparam logic [7:0] IRQ_MSK_OFS = 8'h14;
    localparam logic [7:0] CMD_OFS    = 8'h18;

    // CTRL and CMD fields
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned CTRL_HOLD_BIT  = 1;
    localparam int unsigned CTRL_FALL_BIT  = 2;
    localparam int unsigned CTRL_INF_BIT   = 3;
    localparam int unsigned CTRL_FUNC_LSB  = 4;
    localparam int unsigned CMD_ARM_BIT    = 0;

    // Status / interrupt bits
    localparam int unsigned IRQ_DONE_BIT   = 0;
    localparam int unsigned IRQ_INVAL_BIT  = 1;
    localparam int unsigned IRQ_W          = 2;

    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    localparam logic [31:0] GATE_RST    = 32'h0000_2710;

    typedef enum logic [2:0] {
        FN_FREQ   = 3'h0,
        FN_PERIOD = 3'h1,
        FN_PERAVG = 3'h2,
        FN_WIDTH  = 3'h3,
        FN_TOTAL  = 3'h4
    } meas_fn_t;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_WAIT  = 6'b000010,
        ST_GATE  = 6'b000100,
        ST_PROC  = 6'b001000,
        ST_HOLD  = 6'b010000,
        ST_PAUSE = 6'b100000
    } meas_state_t;

    typedef struct packed {
        logic       enable;
        logic       hold;
        logic       fall;
        logic       infinite;
        meas_fn_t   func;
    } ctrl_t;

    typedef struct packed {
        logic       valid;
        logic       invalid;
        logic [3:0] digits;
        logic [31:0] value;
    } result_t;

endpackage : gated_counter_timer_pkg

// ### hdl/gated_counter_timer.sv
// Functional notes
// - Five measurements: frequency, period, averaged period, width, totalize; gated or unbounded.
// - Continuous mode restarts after gate time plus a 300 ms display pause.
// - Hold mode takes one reading and keeps it until reset/arm.
// - Gate opens on the first valid input edge, not on arming.
// - Digits field reads eight at a gate of one second or more, seven at any shorter gate.
// - Edge select rising or falling, rising after reset.
// - Width times high pulses on rising select, low pulses on falling.
// - Reset/arm zeroes the reading and arms the next measurement.
// - Hold reading starts on valid trigger and ends at gate close.
// - Hold mode result processing takes about 100 ms per reading.
// - Continuous mode with short gates gives at most about three readings per second.
// - Gate shorter than signal period opens but yields no valid result.
// - Counter mode stops waveform generation; never both at once.
// - Counter-active indicator is high while counter mode is on.
// - Completed results are readable by the host in both modes.
`timescale 1ns/1ps
`default_nettype none

module gated_counter_timer #(
    parameter int unsigned PAUSE_CYC     = gated_counter_timer_pkg::PAUSE_CYC_DEF,
    parameter int unsigned PROC_CYC      = gated_counter_timer_pkg::PROC_CYC_DEF,
    parameter int unsigned GATE_UNIT_CYC = gated_counter_timer_pkg::GATE_UNIT_CYC_DEF
) (
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic        counter_input_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output var  logic        s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output var  logic        s_axi_wready_o,
    output var  logic [1:0]  s_axi_bresp_o,
    output var  logic        s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output var  logic        s_axi_arready_o,
    output var  logic [31:0] s_axi_rdata_o,
    output var  logic [1:0]  s_axi_rresp_o,
    output var  logic        s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output var  logic        counter_active_o,
    output var  logic        waveform_enable_o,
    output var  logic        irq_o
);

    // =========================================================
    // Input synchroniser
    // =========================================================
    logic [2:0] in_sync_r;
    logic       in_level_r;
    logic       rise_evt;
    logic       fall_evt;
    logic       sel_evt;

    // Three stages; the level moves only when the last two agree
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            in_sync_r  <= 3'h0;
            in_level_r <= 1'b0;
        end else begin
            in_sync_r <= {in_sync_r[1:0], counter_input_i};
            if (in_sync_r[2] == in_sync_r[1]) begin
                in_level_r <= in_sync_r[2];
            end
        end
    end

    assign rise_evt = (in_sync_r[2] == in_sync_r[1]) && in_sync_r[2] && !in_level_r;
    assign fall_evt = (in_sync_r[2] == in_sync_r[1]) && !in_sync_r[2] && in_level_r;

    // =========================================================
    // Registers and bus slave
    // =========================================================
    gated_counter_timer_pkg::ctrl_t   ctrl_r;
    gated_counter_timer_pkg::result_t result_r;
    gated_counter_timer_pkg::meas_state_t state_r;
    logic [31:0]                      gate_units_r;
    logic [gated_counter_timer_pkg::IRQ_W-1:0] irq_sts_r;
    logic [gated_counter_timer_pkg::IRQ_W-1:0] irq_msk_r;
    logic [gated_counter_timer_pkg::IRQ_W-1:0] irq_evt;
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic        wr_fire;
    logic        arm_pulse;
    logic [31:0] rd_mux;
    logic        rd_ok;

    assign wr_fire   = aw_hold_r && w_hold_r && !s_axi_bvalid_o;
    assign arm_pulse = wr_fire && (awaddr_r == gated_counter_timer_pkg::CMD_OFS)
                       && wdata_r[gated_counter_timer_pkg::CMD_ARM_BIT];

    // Address and data are latched independently, in either order
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            aw_hold_r       <= 1'b0;
            w_hold_r        <= 1'b0;
            awaddr_r        <= 8'h00;
            wdata_r         <= 32'h0000_0000;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= gated_counter_timer_pkg::RESP_OKAY;
        end else begin
            s_axi_awready_o <= !aw_hold_r && !s_axi_awready_o && s_axi_awvalid_i;
            s_axi_wready_o  <= !w_hold_r && !s_axi_wready_o && s_axi_wvalid_i;
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata_i;
            end
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= (awaddr_r <= gated_counter_timer_pkg::CMD_OFS
                                   && awaddr_r[1:0] == 2'b00)
                                  ? gated_counter_timer_pkg::RESP_OKAY
                                  : gated_counter_timer_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                aw_hold_r      <= 1'b0;
                w_hold_r       <= 1'b0;
            end
        end
    end

    // Writable configuration; byte strobes ignored on every field
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            ctrl_r       <= '{enable: 1'b0, hold: 1'b0, fall: 1'b0, infinite: 1'b0,
                              func: gated_counter_timer_pkg::FN_FREQ};
            gate_units_r <= gated_counter_timer_pkg::GATE_RST;
            irq_msk_r    <= '0;
        end else if (wr_fire) begin
            case (awaddr_r)
                gated_counter_timer_pkg::CTRL_OFS: begin
                    ctrl_r.enable   <= wdata_r[gated_counter_timer_pkg::CTRL_EN_BIT];
                    ctrl_r.hold     <= wdata_r[gated_counter_timer_pkg::CTRL_HOLD_BIT];
                    ctrl_r.fall     <= wdata_r[gated_counter_timer_pkg::CTRL_FALL_BIT];
                    ctrl_r.infinite <= wdata_r[gated_counter_timer_pkg::CTRL_INF_BIT];
                    ctrl_r.func     <= gated_counter_timer_pkg::meas_fn_t'(
                        wdata_r[gated_counter_timer_pkg::CTRL_FUNC_LSB +: 3]);
                end
                gated_counter_timer_pkg::GATE_OFS:   gate_units_r <= wdata_r;
                gated_counter_timer_pkg::IRQ_MSK_OFS:
                    irq_msk_r <= wdata_r[gated_counter_timer_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Read decode
    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr_i)
            gated_counter_timer_pkg::CTRL_OFS:
                rd_mux = {25'h0, ctrl_r.func, ctrl_r.infinite, ctrl_r.fall,
                          ctrl_r.hold, ctrl_r.enable};
            gated_counter_timer_pkg::GATE_OFS:   rd_mux = gate_units_r;
            gated_counter_timer_pkg::STAT_OFS:
                rd_mux = {20'h0, result_r.digits, 2'h0, state_r};
            gated_counter_timer_pkg::RESULT_OFS: rd_mux = result_r.value;
            gated_counter_timer_pkg::IRQ_STS_OFS: rd_mux = {30'h0, irq_sts_r};
            gated_counter_timer_pkg::IRQ_MSK_OFS: rd_mux = {30'h0, irq_msk_r};
            gated_counter_timer_pkg::CMD_OFS:    rd_mux = 32'h0000_0000;
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel answers two cycles after arvalid
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= gated_counter_timer_pkg::RESP_OKAY;
        end else begin
            s_axi_arready_o <= s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o  <= rd_mux;
                s_axi_rresp_o  <= rd_ok ? gated_counter_timer_pkg::RESP_OKAY
                                        : gated_counter_timer_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // =========================================================
    // Measurement engine
    // =========================================================
    logic [31:0] unit_cnt_r;
    logic [31:0] units_r;
    logic [31:0] wait_cnt_r;
    logic [31:0] ref_cnt_r;
    logic [31:0] edge_cnt_r;
    logic [31:0] span_ref_r;
    logic        trig_evt;
    logic        width_end_evt;
    logic        gate_done;
    logic        timed_fn;

    assign trig_evt      = ctrl_r.fall ? fall_evt : rise_evt;
    assign width_end_evt = ctrl_r.fall ? rise_evt : fall_evt;
    assign timed_fn      = (ctrl_r.func == gated_counter_timer_pkg::FN_PERIOD)
                           || (ctrl_r.func == gated_counter_timer_pkg::FN_WIDTH);
    // Period and width gates close on the edge that ends the span; an infinite counting gate never closes
    assign gate_done = timed_fn ? (ctrl_r.func == gated_counter_timer_pkg::FN_WIDTH
                                   ? width_end_evt : trig_evt)
                     : (!ctrl_r.infinite && units_r >= gate_units_r);

    // Gate timing in coarse steps keeps the comparator narrow
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || state_r != gated_counter_timer_pkg::ST_GATE) begin
            unit_cnt_r <= 32'h0000_0000;
            units_r    <= 32'h0000_0000;
        end else if (unit_cnt_r == GATE_UNIT_CYC - 1) begin
            unit_cnt_r <= 32'h0000_0000;
            units_r    <= units_r + 32'h0000_0001;
        end else begin
            unit_cnt_r <= unit_cnt_r + 32'h0000_0001;
        end
    end

    // Sequencer: idle, wait trigger, gate, process, hold or pause
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || !ctrl_r.enable) begin
            state_r    <= gated_counter_timer_pkg::ST_IDLE;
            wait_cnt_r <= 32'h0000_0000;
        end else begin
            case (state_r)
                gated_counter_timer_pkg::ST_IDLE: state_r <= gated_counter_timer_pkg::ST_WAIT;
                gated_counter_timer_pkg::ST_WAIT: begin
                    if (arm_pulse) state_r <= gated_counter_timer_pkg::ST_WAIT;
                    else if (trig_evt) state_r <= gated_counter_timer_pkg::ST_GATE;
                end
                gated_counter_timer_pkg::ST_GATE: begin
                    wait_cnt_r <= 32'h0000_0000;
                    if (arm_pulse) state_r <= gated_counter_timer_pkg::ST_WAIT;
                    else if (gate_done) state_r <= gated_counter_timer_pkg::ST_PROC;
                end
                gated_counter_timer_pkg::ST_PROC: begin
                    wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
                    if (arm_pulse) state_r <= gated_counter_timer_pkg::ST_WAIT;
                    else if (wait_cnt_r >= PROC_CYC - 1) begin
                        wait_cnt_r <= 32'h0000_0000;
                        state_r <= ctrl_r.hold ? gated_counter_timer_pkg::ST_HOLD
                                               : gated_counter_timer_pkg::ST_PAUSE;
                    end
                end
                gated_counter_timer_pkg::ST_HOLD: begin
                    if (arm_pulse) state_r <= gated_counter_timer_pkg::ST_WAIT;
                end
                gated_counter_timer_pkg::ST_PAUSE: begin
                    wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
                    if (arm_pulse) state_r <= gated_counter_timer_pkg::ST_WAIT;
                    else if (wait_cnt_r + PROC_CYC >= PAUSE_CYC - 1)
                        state_r <= gated_counter_timer_pkg::ST_WAIT;
                end
                default: state_r <= gated_counter_timer_pkg::ST_IDLE;
            endcase
        end
    end

    // Reference clocks and input edges counted while the gate is open
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || state_r == gated_counter_timer_pkg::ST_WAIT) begin
            ref_cnt_r  <= 32'h0000_0000;
            edge_cnt_r <= 32'h0000_0000;
            span_ref_r <= 32'h0000_0000;
        end else if (state_r == gated_counter_timer_pkg::ST_GATE) begin
            ref_cnt_r <= ref_cnt_r + 32'h0000_0001;
            if (trig_evt) begin
                edge_cnt_r <= edge_cnt_r + 32'h0000_0001;
                span_ref_r <= ref_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Result selection per function; zeroed by reset/arm
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || arm_pulse) begin
            result_r <= '0;
        end else if (state_r == gated_counter_timer_pkg::ST_GATE && gate_done) begin
            result_r.valid  <= 1'b1;
            // Digits follow the programmed gate, not the time the span took
            result_r.digits <= (gate_units_r >= gated_counter_timer_pkg::GATE_1S_UNITS)
                ? 4'(gated_counter_timer_pkg::DIGITS_1S)
                : 4'(gated_counter_timer_pkg::DIGITS_1S - 1);
            result_r.invalid <= 1'b0;
            case (ctrl_r.func)
                gated_counter_timer_pkg::FN_FREQ,
                gated_counter_timer_pkg::FN_TOTAL:  result_r.value <= edge_cnt_r;
                gated_counter_timer_pkg::FN_PERIOD,
                gated_counter_timer_pkg::FN_WIDTH:  result_r.value <= ref_cnt_r + 32'h1;
                gated_counter_timer_pkg::FN_PERAVG: begin
                    // Average left as span over edges: host divides, saves a divider
                    result_r.value <= span_ref_r;
                    result_r.invalid <= (edge_cnt_r == 32'h0000_0000);
                end
                default: result_r.value <= 32'h0000_0000;
            endcase
            if (!timed_fn && edge_cnt_r == 32'h0000_0000) begin
                result_r.valid   <= 1'b0;
                result_r.invalid <= 1'b1;
            end
        end
    end

    // =========================================================
    // Interrupts and indicators
    // =========================================================
    assign irq_evt[gated_counter_timer_pkg::IRQ_DONE_BIT] =
        state_r == gated_counter_timer_pkg::ST_PROC && wait_cnt_r == 32'h0000_0000;
    assign irq_evt[gated_counter_timer_pkg::IRQ_INVAL_BIT] =
        irq_evt[gated_counter_timer_pkg::IRQ_DONE_BIT] && result_r.invalid;

    // Write one to clear; a same-cycle event wins
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            irq_sts_r <= '0;
        end else begin
            irq_sts_r <= (irq_sts_r & ~((wr_fire && awaddr_r == gated_counter_timer_pkg::IRQ_STS_OFS)
                          ? wdata_r[gated_counter_timer_pkg::IRQ_W-1:0] : 2'b00)) | irq_evt;
        end
    end

    // Counter mode and waveform output are mutually exclusive
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            counter_active_o  <= 1'b0;
            waveform_enable_o <= 1'b0;
            irq_o             <= 1'b0;
        end else begin
            counter_active_o  <= ctrl_r.enable;
            waveform_enable_o <= !ctrl_r.enable;
            irq_o             <= |(irq_sts_r & irq_msk_r);
        end
    end

endmodule : gated_counter_timer

`default_nettype wire

// ### tb/gated_counter_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker
module gct_port_checker (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        counter_active_o,
    input wire logic        waveform_enable_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // Request phases and bounded answers
    sequence s_wr_req;
        s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
    endsequence
    sequence s_wr_ans;
        ##[1:4] s_axi_bvalid_o;
    endsequence
    sequence s_rd_ans;
        ##[1:4] s_axi_rvalid_o;
    endsequence
    a_mode_exclusive: assert property (!(counter_active_o && waveform_enable_o))
        else $error("counter and waveform both on");
    a_mode_present: assert property ($past(reset_n_i) |-> counter_active_o != waveform_enable_o)
        else $error("neither counter nor waveform on");
    a_write_answer: assert property (s_wr_req |-> s_wr_ans)
        else $error("write response missing");
    a_read_answer: assert property ($rose(s_axi_arvalid_i) |-> s_rd_ans)
        else $error("read response missing");
    a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("bvalid dropped early");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data not held");
    a_awready_pulse: assert property (s_axi_awready_o |=> !s_axi_awready_o)
        else $error("awready longer than one cycle");
    a_refused_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == 2'b10
        |-> s_axi_rdata_o == 32'h0)
        else $error("refused read returned data");
endmodule : gct_port_checker
bind gated_counter_timer gct_port_checker chk_u (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o), .counter_active_o(counter_active_o),
    .waveform_enable_o(waveform_enable_o));
`default_nettype wire

// ### tb/signal_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// External pulse source
module signal_source #(
    parameter int HI_NS = 40,
    parameter int LO_NS = 60
) (
    input  wire logic run_i,
    output logic      sig_o
);
    // Idle low while stopped; 1 ns offset keeps edges off the clock edge
    initial begin
        sig_o = 1'b0;
        forever begin
            wait (run_i === 1'b1);
            #1;
            while (run_i === 1'b1) begin
                sig_o = 1'b1;
                #(HI_NS);
                sig_o = 1'b0;
                #(LO_NS);
            end
        end
    end
endmodule : signal_source
`default_nettype wire

// ### tb/gated_counter_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gated_counter_timer_tb;
    // ==========================================
    // Signals
    localparam logic [1:0] OK  = gated_counter_timer_pkg::RESP_OKAY;
    localparam logic [7:0] CT  = gated_counter_timer_pkg::CTRL_OFS;
    localparam logic [7:0] GT  = gated_counter_timer_pkg::GATE_OFS;
    localparam logic [7:0] STA = gated_counter_timer_pkg::STAT_OFS;
    localparam logic [7:0] RES = gated_counter_timer_pkg::RESULT_OFS;
    localparam logic [7:0] STS = gated_counter_timer_pkg::IRQ_STS_OFS;
    localparam logic [7:0] MSK = gated_counter_timer_pkg::IRQ_MSK_OFS;
    localparam logic [7:0] CMD = gated_counter_timer_pkg::CMD_OFS;
    logic        clock_i = 1'b0, reset_n_i = 1'b0, src_run = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, active, wave, irq;
    logic [1:0]  bresp, rresp;
    wire logic   sig;
    int          err_count = 0, comparisons = 0, cycles = 0;
    always #2 clock_i = ~clock_i;
    signal_source src_u (.run_i(src_run), .sig_o(sig));
    // Short counts keep the run brief
    gated_counter_timer #(.PAUSE_CYC(40), .PROC_CYC(10), .GATE_UNIT_CYC(4)) dut_u (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .counter_input_i(sig),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .counter_active_o(active),
        .waveform_enable_o(wave), .irq_o(irq));
    // ==========================================
    // Tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Each bus task starts on a fresh edge so no signal is assigned twice at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk($sformatf("bresp %h", a), {30'h0, r}, {30'h0, bresp});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk($sformatf("rdata %h", a), e, rdata);
        chk($sformatf("rresp %h", a), {30'h0, r}, {30'h0, rresp});
    endtask : rd
    task automatic wait_irq();
        int n = 0;
        // Let a clear written just before settle on the registered pin
        @(posedge clock_i);
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clock_i);
            n++;
        end
        chk("irq", 32'h1, {31'h0, irq});
    endtask : wait_irq
    // One armed hold reading: source stays still until the block waits
    task automatic meas(input logic [31:0] c, input logic [31:0] e, input logic [31:0] s,
                        input logic [3:0] d);
        wr(CT, c, OK);
        wr(CMD, 32'h1, OK);
        rd(RES, 32'h0, OK);
        repeat (40) @(posedge clock_i);
        rd(STA, 32'h0000_0002, OK);
        wr(STS, 32'h3, OK);
        src_run <= 1'b1;
        wait_irq();
        src_run <= 1'b0;
        repeat (40) @(posedge clock_i);
        rd(RES, e, OK);
        rd(STA, {20'h0, d, 8'h10}, OK);
        rd(STS, s, OK);
    endtask : meas
    // ==========================================
    // Watchdog and main sequence
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk("waveform on", 32'h1, {31'h0, wave});
        chk("active off", 32'h0, {31'h0, active});
        rd(CT, 32'h0, OK);
        rd(GT, gated_counter_timer_pkg::GATE_RST, OK);
        rd(8'h1C, 32'h0, 2'b10);
        wr(8'h1C, 32'h5, 2'b10);
        wr(MSK, 32'h1, OK);
        meas(32'h13, 32'h0000_0019, 32'h1, 4'd8);
        chk("active on", 32'h1, {31'h0, active});
        chk("waveform off", 32'h0, {31'h0, wave});
        repeat (100) @(posedge clock_i);
        rd(RES, 32'h0000_0019, OK);
        meas(32'h33, 32'h0000_000A, 32'h1, 4'd8);
        meas(32'h37, 32'h0000_000F, 32'h1, 4'd8);
        wr(GT, 32'h1, OK);
        meas(32'h03, 32'h0, 32'h3, 4'd7);
        wr(MSK, 32'h0, OK);
        repeat (2) @(posedge clock_i);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(STS, 32'h3, OK);
        wr(MSK, 32'h1, OK);
        wr(GT, gated_counter_timer_pkg::GATE_RST, OK);
        wr(CT, 32'h11, OK);
        wr(CMD, 32'h1, OK);
        wr(STS, 32'h3, OK);
        src_run <= 1'b1;
        wait_irq();
        wr(STS, 32'h3, OK);
        wait_irq();
        src_run <= 1'b0;
        wr(CT, 32'h0, OK);
        repeat (2) @(posedge clock_i);
        chk("active off", 32'h0, {31'h0, active});
        chk("waveform on", 32'h1, {31'h0, wave});
        summarize();
    end
endmodule : gated_counter_timer_tb
`default_nettype wire
